// ==== hdl/fcp_defs.svh ====
// Constants shared by both ends of the coprocessor port
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH
`define FCP_UOP_W       16
`define FCP_DATA_W      64
`define FCP_TAG_W       5
`define FCP_TERM_W      2
`define FCP_TSTAT_W     6
`define FCP_OTYP_W      2
`define FCP_TSTAT_ISSUE 0
`define FCP_TSTAT_RETIRE 1
`define FCP_TSTAT_ABORT 2
`define FCP_TSTAT_ID_LSB 3
`define FCP_TSTAT_ID_W  3
`endif

// ==== hdl/fcp_pkg.sv ====
// Types for the coprocessor port
`include "fcp_defs.svh"
package fcp_pkg;
  typedef logic [`FCP_DATA_W-1:0] fcp_data_t;
  typedef logic [`FCP_TAG_W-1:0]  fcp_tag_t;
  typedef enum logic [1:0] {FCP_OWN_IDLE, FCP_OWN_READ, FCP_OWN_WRITE} fcp_owner_e;
endpackage

// ==== hdl/fcp_link_if.sv ====
// Interface joining processor and coprocessor ends
`timescale 1ns/1ps
`include "fcp_defs.svh"
interface fcp_link_if;
  logic [`FCP_UOP_W-1:0]   fp_microop_bus;
  logic                    fp_microop_vld;
  logic                    read_request_out;
  logic                    read_valid_out;
  logic                    write_request_in;
  logic                    write_valid_in;
  logic [`FCP_TERM_W-1:0]  fp_op_termination;
  logic [`FCP_TSTAT_W-1:0] fp_tag_status;
  logic                    fp_no_error_hs;
  logic [`FCP_OTYP_W-1:0]  fp_output_type_hs;
  logic [`FCP_DATA_W-1:0]  cpu_data_o;
  logic                    cpu_data_oe;
  logic [`FCP_TAG_W-1:0]   cpu_tag_o;
  logic [`FCP_DATA_W-1:0]  np_data_o;
  logic                    np_data_oe;
  logic [`FCP_TAG_W-1:0]   np_tag_o;
  logic [`FCP_DATA_W-1:0]  copro_data_bus;
  logic [`FCP_TAG_W-1:0]   microop_tag_bus;
  // Resolved shared wires; the coprocessor wins only while it alone drives
  assign copro_data_bus  = (np_data_oe && !cpu_data_oe) ? np_data_o : cpu_data_o;
  assign microop_tag_bus = (np_data_oe && !cpu_data_oe) ? np_tag_o  : cpu_tag_o;
  modport cpu (output fp_microop_bus, fp_microop_vld, read_request_out, read_valid_out,
               fp_tag_status, fp_output_type_hs, cpu_data_o, cpu_data_oe, cpu_tag_o,
               input write_request_in, write_valid_in, fp_op_termination, fp_no_error_hs,
               copro_data_bus, microop_tag_bus, np_data_oe);
  modport np  (input fp_microop_bus, fp_microop_vld, read_request_out, read_valid_out,
               fp_tag_status, fp_output_type_hs, copro_data_bus, microop_tag_bus,
               cpu_data_oe,
               output write_request_in, write_valid_in, fp_op_termination, fp_no_error_hs,
               np_data_o, np_data_oe, np_tag_o);
endinterface

// ==== hdl/fcp_arbiter.sv ====
// Pipelined bus arbiter kept identically by both ends
`timescale 1ns/1ps
module fcp_arbiter
  import fcp_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       rd_req_i,
  input  wire logic       wr_req_i,
  output fcp_owner_e      owner_o
);
  fcp_owner_e owner_q;
  fcp_owner_e owner_d;

  always_comb begin
    // Read beats write; grant applies to the next clock
    if (rd_req_i) begin
      owner_d = FCP_OWN_READ;  // [RQ4] [RQ6]
    end else if (wr_req_i) begin
      owner_d = FCP_OWN_WRITE; // [RQ6]
    end else begin
      owner_d = FCP_OWN_IDLE;  // [RQ5]
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      owner_q <= FCP_OWN_IDLE; // [RQ17]
    end else begin
      owner_q <= owner_d;
    end
  end

  assign owner_o = owner_q;
endmodule

// ==== hdl/fcp_cpu_end.sv ====
// Processor end of the coprocessor port
//
// What the two port ends do
// RQ1: Drive micro-op and tag, one per clock. The code issues the micro-op with no tag of its own.
// RQ2: Raise read request one clock before transfer.
// RQ3: Coprocessor raises write request one clock early.
// RQ4: Read request beats simultaneous write request.
// RQ5: Processor drives data bus when nobody requested.
// RQ6: Winner owns bus in the following clock.
// RQ7: Read-valid with data, or withdraw speculative read.
// RQ8: Read-valid marks data valid that clock.
// RQ9: Coprocessor write-valid with result, or withdraws.
// RQ10: Write-valid marks result valid that clock.
// RQ11: Bus owner drives matching tag every clock.
// RQ12: Data bus carries 64 bits either way.
// RQ13: Coprocessor reports completion on termination pins.
// RQ14: Processor drives six-bit tag status.
// RQ15: Coprocessor drives no-error handshake, software gated.
// RQ16: Processor drives output-type handshake, software gated.
// RQ17: Reset drops requests and valids; processor owns bus.
//
// Read timing in processor clocks, c0 being the clock rd_req_i is high:
//   c1  read_request_out high; rd_data_i and rd_tag_i must be valid here
//   c2  bus granted and driven from registers; rd_usable_i low withdraws
//   c3  coprocessor end strobes the captured operand
// Writes run the same way from the other end; reads win every tie.
`timescale 1ns/1ps
`include "fcp_defs.svh"
module fcp_cpu_end
  import fcp_pkg::*;
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    arst_n_i,
  fcp_link_if.cpu                      lnk,
  input  wire logic                    uop_vld_i,
  input  wire logic [`FCP_UOP_W-1:0]   uop_i,
  input  wire logic                    rd_req_i,
  input  wire logic                    rd_usable_i,
  input  wire fcp_data_t               rd_data_i,
  input  wire fcp_tag_t                rd_tag_i,
  output logic                         rd_sent_o,
  output fcp_data_t                    wr_data_o,
  output fcp_tag_t                     wr_tag_o,
  output logic                         wr_strobe_o,
  output logic [`FCP_TERM_W-1:0]       term_o,
  input  wire logic [`FCP_TSTAT_W-1:0] tag_status_i,
  input  wire logic                    compat_en_i,
  input  wire logic [`FCP_OTYP_W-1:0]  out_type_i,
  output logic                         no_error_o
);
  fcp_owner_e                owner;
  logic                      rd_slot;
  // Micro-op issue
  logic [`FCP_UOP_W-1:0]     uop_q;
  logic [`FCP_UOP_W-1:0]     uop_d;
  logic                      uop_vld_q;
  logic                      uop_vld_d;
  // Status and output-type handshake towards the coprocessor
  logic [`FCP_TSTAT_W-1:0]   tstat_q;
  logic [`FCP_TSTAT_W-1:0]   tstat_d;
  logic [`FCP_OTYP_W-1:0]    otyp_q;
  logic [`FCP_OTYP_W-1:0]    otyp_d;
  // Read request and outgoing operand
  logic                      rreq_q;
  logic                      rreq_d;
  fcp_data_t                 rdat_q;
  fcp_data_t                 rdat_d;
  fcp_tag_t                  rtag_q;
  fcp_tag_t                  rtag_d;
  // Result capture
  fcp_data_t                 wdat_q;
  fcp_data_t                 wdat_d;
  fcp_tag_t                  wtag_q;
  fcp_tag_t                  wtag_d;
  logic                      wstb_q;
  logic                      wstb_d;
  // Completion and no-error handshake from the coprocessor
  logic [`FCP_TERM_W-1:0]    term_q;
  logic [`FCP_TERM_W-1:0]    term_d;
  logic                      noerr_q;
  logic                      noerr_d;

  fcp_arbiter i_fcp_arbiter (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .rd_req_i  (rreq_q),
    .wr_req_i  (lnk.write_request_in),
    .owner_o   (owner)
  );

  assign rd_slot = (owner == FCP_OWN_READ);

  // Micro-op issue, held on the bus between issues
  always_comb begin
    uop_d     = uop_vld_i ? uop_i : uop_q; // [RQ1]
    uop_vld_d = uop_vld_i;                 // [RQ1]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uop_q     <= '0;
      uop_vld_q <= 1'b0;
    end else begin
      uop_q     <= uop_d;
      uop_vld_q <= uop_vld_d;
    end
  end

  // Status goes out every clock; output type only while software allows it
  always_comb begin
    tstat_d = tag_status_i;                  // [RQ14]
    otyp_d  = compat_en_i ? out_type_i : '0; // [RQ16]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tstat_q <= '0;
      otyp_q  <= '0;
    end else begin
      tstat_q <= tstat_d;
      otyp_q  <= otyp_d;
    end
  end

  // The operand is loaded in the request clock so that the grant clock
  // drives the bus from a flip-flop rather than from the user side
  always_comb begin
    rreq_d = rd_req_i;                // [RQ2]
    // Cleared in every other clock: a read always wins its request clock,
    // so the registers are non-zero only in a read slot
    rdat_d = rreq_q ? rd_data_i : '0; // [RQ7] [RQ12]
    rtag_d = rreq_q ? rd_tag_i : '0;  // [RQ11]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rreq_q <= 1'b0; // [RQ17]
      rdat_q <= '0;
      rtag_q <= '0;
    end else begin
      rreq_q <= rreq_d;
      rdat_q <= rdat_d;
      rtag_q <= rtag_d;
    end
  end

  // Results are taken only when the coprocessor owns the bus and says
  // valid; a withdrawn write leaves the last result untouched
  always_comb begin
    wstb_d = (owner == FCP_OWN_WRITE) && lnk.write_valid_in; // [RQ10]
    wdat_d = wstb_d ? lnk.copro_data_bus : wdat_q;            // [RQ12]
    wtag_d = wstb_d ? lnk.microop_tag_bus : wtag_q;           // [RQ11]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdat_q <= '0;
      wtag_q <= '0;
      wstb_q <= 1'b0;
    end else begin
      wdat_q <= wdat_d;
      wtag_q <= wtag_d;
      wstb_q <= wstb_d;
    end
  end

  // Termination idles high in reset, like its pulled-up pins
  always_comb begin
    term_d = lnk.fp_op_termination; // [RQ13]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      term_q <= '1;
    end else begin
      term_q <= term_d;
    end
  end

  // No-error handshake, pulled-up level whenever software disables it
  always_comb begin
    noerr_d = compat_en_i ? lnk.fp_no_error_hs : 1'b1; // [RQ15]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      noerr_q <= 1'b1;
    end else begin
      noerr_q <= noerr_d;
    end
  end

  assign lnk.fp_microop_bus    = uop_q;
  assign lnk.fp_microop_vld    = uop_vld_q;
  assign lnk.read_request_out  = rreq_q;
  assign lnk.fp_tag_status     = tstat_q;
  assign lnk.fp_output_type_hs = otyp_q;
  // A speculative read is withdrawn in the grant clock by rd_usable_i low;
  // that decision is the only combinational path onto the link
  assign lnk.read_valid_out = rd_slot && rd_usable_i;   // [RQ7] [RQ8]
  assign lnk.cpu_data_oe    = (owner != FCP_OWN_WRITE); // [RQ5]
  assign lnk.cpu_data_o     = rdat_q;                   // [RQ7] [RQ12]
  assign lnk.cpu_tag_o      = rtag_q;                   // [RQ11]

  assign rd_sent_o          = rd_slot && rd_usable_i;
  assign wr_data_o          = wdat_q;
  assign wr_tag_o           = wtag_q;
  assign wr_strobe_o        = wstb_q;
  assign term_o             = term_q;
  assign no_error_o         = noerr_q;
endmodule

// ==== hdl/fcp_np_end.sv ====
// Coprocessor end of the coprocessor port
`timescale 1ns/1ps
`include "fcp_defs.svh"
module fcp_np_end
  import fcp_pkg::*;
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  fcp_link_if.np                        lnk,
  output logic [`FCP_UOP_W-1:0]         uop_o,
  output logic                          uop_vld_o,
  output logic [`FCP_TSTAT_W-1:0]       tag_status_o,
  output logic [`FCP_OTYP_W-1:0]        out_type_o,
  output fcp_data_t                     rd_data_o,
  output fcp_tag_t                      rd_tag_o,
  output logic                          rd_strobe_o,
  input  wire logic                     wr_req_i,
  input  wire logic                     wr_ready_i,
  input  wire fcp_data_t                wr_data_i,
  input  wire fcp_tag_t                 wr_tag_i,
  output logic                          wr_sent_o,
  input  wire logic [`FCP_TERM_W-1:0]   term_i,
  input  wire logic                     no_error_i
);
  fcp_owner_e              owner;
  logic                    wreq_q, wreq_d;
  fcp_data_t               wdat_q, wdat_d;
  fcp_tag_t                wtag_q, wtag_d;
  fcp_data_t               rdat_q, rdat_d;
  fcp_tag_t                rtag_q, rtag_d;
  logic                    rstb_q, rstb_d;
  logic [`FCP_TERM_W-1:0]  term_q, term_d;
  logic                    noerr_q, noerr_d;
  logic                    wr_slot;

  fcp_arbiter i_fcp_arbiter (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .rd_req_i  (lnk.read_request_out),
    .wr_req_i  (wreq_q),
    .owner_o   (owner)
  );

  assign wr_slot = (owner == FCP_OWN_WRITE);

  always_comb begin
    wreq_d  = wr_req_i;                                     // [RQ3]
    // Result is loaded in the clock whose request will win, so the grant
    // clock drives the bus from a flip-flop; it clears in every other clock
    wdat_d  = (wreq_q && !lnk.read_request_out) ? wr_data_i : '0; // [RQ9] [RQ12]
    wtag_d  = (wreq_q && !lnk.read_request_out) ? wr_tag_i : '0;  // [RQ11]
    rstb_d  = (owner == FCP_OWN_READ) && lnk.read_valid_out; // [RQ8]
    rdat_d  = rstb_d ? lnk.copro_data_bus : rdat_q;
    rtag_d  = rstb_d ? lnk.microop_tag_bus : rtag_q;         // [RQ11]
    term_d  = term_i;                                       // [RQ13]
    noerr_d = no_error_i;                                   // [RQ15]
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wreq_q  <= 1'b0; // [RQ17]
      wdat_q  <= '0;
      wtag_q  <= '0;
      rdat_q  <= '0;
      rtag_q  <= '0;
      rstb_q  <= 1'b0;
      term_q  <= '1;
      noerr_q <= 1'b1;
    end else begin
      wreq_q  <= wreq_d;
      wdat_q  <= wdat_d;
      wtag_q  <= wtag_d;
      rdat_q  <= rdat_d;
      rtag_q  <= rtag_d;
      rstb_q  <= rstb_d;
      term_q  <= term_d;
      noerr_q <= noerr_d;
    end
  end

  assign lnk.write_request_in  = wreq_q;
  // Speculative write withdrawn by leaving valid low when formatting is unfinished
  assign lnk.write_valid_in    = wr_slot && wr_ready_i;       // [RQ9] [RQ10]
  assign lnk.np_data_oe        = wr_slot;                     // [RQ6]
  assign lnk.np_data_o         = wdat_q;                      // [RQ12]
  assign lnk.np_tag_o          = wtag_q;                      // [RQ11]
  assign lnk.fp_op_termination = term_q;
  assign lnk.fp_no_error_hs    = noerr_q;
  assign uop_o                 = lnk.fp_microop_bus;
  assign uop_vld_o             = lnk.fp_microop_vld;
  assign tag_status_o          = lnk.fp_tag_status;
  assign out_type_o            = lnk.fp_output_type_hs;
  assign rd_data_o             = rdat_q;
  assign rd_tag_o              = rtag_q;
  assign rd_strobe_o           = rstb_q;
  assign wr_sent_o             = wr_slot && wr_ready_i;
endmodule

// ==== test/fcp_link_chk.sv ====
// Concurrent checks on the arbitration wires between the two port ends
`timescale 1ns/1ps
module fcp_link_chk (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic read_request_out,
  input wire logic read_valid_out,
  input wire logic write_request_in,
  input wire logic write_valid_in,
  input wire logic cpu_data_oe,
  input wire logic np_data_oe
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_rst;
    $rose(arst_n_i) |-> !read_request_out && !write_request_in && cpu_data_oe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("requests or ownership wrong after reset");
  property p_rd_grant;
    read_request_out |=> cpu_data_oe && !np_data_oe && !write_valid_in;
  endproperty
  a_rd_grant: assert property (p_rd_grant)
    else $error("read winner does not own the bus next clock");
  property p_wr_grant;
    write_request_in && !read_request_out |=> np_data_oe && !cpu_data_oe;
  endproperty
  a_wr_grant: assert property (p_wr_grant)
    else $error("write winner does not own the bus next clock");
  property p_wr_lose;
    read_request_out && write_request_in |=> !np_data_oe ##0 !write_valid_in;
  endproperty
  a_wr_lose: assert property (p_wr_lose)
    else $error("write request beat a read request");
  property p_idle;
    !read_request_out && !write_request_in |=> cpu_data_oe && !read_valid_out && !write_valid_in;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle clock not driven by processor");
  property p_rval;
    read_valid_out |-> $past(read_request_out);
  endproperty
  a_rval: assert property (p_rval)
    else $error("read valid without a request one clock earlier");
  property p_wval;
    write_valid_in |-> $past(write_request_in && !read_request_out) && np_data_oe;
  endproperty
  a_wval: assert property (p_wval)
    else $error("write valid without a won request");
  property p_excl;
    !(cpu_data_oe && np_data_oe);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both ends drive the data bus");
endmodule

// ==== test/test_fpu_coprocessor_bus_port.sv ====
// Testbench joining both port ends across the link interface
`timescale 1ns/1ps
module test_fpu_coprocessor_bus_port
  import fcp_pkg::*;
;
  logic        sys_clk_i, arst_n_i, uop_vld_i, rd_req_i, rd_usable_i, wr_req_i, wr_ready_i;
  logic        compat_en_i, no_error_i, rd_sent_o, wr_strobe_o, no_error_o;
  logic        uop_vld_o, rd_strobe_o, wr_sent_o;
  logic [15:0] uop_i, uop_o;
  logic [5:0]  tag_status_i, tag_status_o;
  logic [1:0]  out_type_i, out_type_o, term_i, term_o;
  fcp_data_t   rd_data_i, wr_data_i, rd_data_o, wr_data_o;
  fcp_tag_t    rd_tag_i, wr_tag_i, rd_tag_o, wr_tag_o;
  int          n_fail, n_compared, cyc;
  fcp_link_if i_lnk ();
  fcp_cpu_end i_fcp_cpu_end (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .lnk(i_lnk),
    .uop_vld_i(uop_vld_i), .uop_i(uop_i), .rd_req_i(rd_req_i), .rd_usable_i(rd_usable_i),
    .rd_data_i(rd_data_i), .rd_tag_i(rd_tag_i), .rd_sent_o(rd_sent_o), .wr_data_o(wr_data_o),
    .wr_tag_o(wr_tag_o), .wr_strobe_o(wr_strobe_o), .term_o(term_o),
    .tag_status_i(tag_status_i), .compat_en_i(compat_en_i), .out_type_i(out_type_i),
    .no_error_o(no_error_o));
  fcp_np_end i_fcp_np_end (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .lnk(i_lnk),
    .uop_o(uop_o), .uop_vld_o(uop_vld_o), .tag_status_o(tag_status_o),
    .out_type_o(out_type_o), .rd_data_o(rd_data_o), .rd_tag_o(rd_tag_o),
    .rd_strobe_o(rd_strobe_o), .wr_req_i(wr_req_i), .wr_ready_i(wr_ready_i),
    .wr_data_i(wr_data_i), .wr_tag_i(wr_tag_i), .wr_sent_o(wr_sent_o), .term_i(term_i),
    .no_error_i(no_error_i));
  fcp_link_chk i_fcp_link_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .read_request_out(i_lnk.read_request_out), .read_valid_out(i_lnk.read_valid_out),
    .write_request_in(i_lnk.write_request_in), .write_valid_in(i_lnk.write_valid_in),
    .cpu_data_oe(i_lnk.cpu_data_oe), .np_data_oe(i_lnk.np_data_oe));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic results();
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A whole run needs well under 200 clocks
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // One request clock, then the grant clock, then the capture clock
  task automatic xfer(input logic rq, wq, ru, wr, input fcp_data_t rd, wd,
                      input fcp_tag_t rt, wt);
    logic rv, wv;
    rv = rq & ru;
    wv = wq & !rq & wr;
    {rd_req_i, wr_req_i, rd_usable_i, wr_ready_i} = {rq, wq, ru, wr};
    {rd_data_i, wr_data_i, rd_tag_i, wr_tag_i} = {rd, wd, rt, wt};
    tick(1);
    {rd_req_i, wr_req_i} = 2'b00;
    tick(1);
    chk(i_lnk.read_valid_out, rv, "read valid");
    chk(i_lnk.write_valid_in, wv, "write valid");
    chk({rd_sent_o, wr_sent_o}, {rv, wv}, "sent pulses");
    if (rv || wv) chk(i_lnk.copro_data_bus, wv ? wd : rd, "data bus");
    if (rv || wv) chk(i_lnk.microop_tag_bus, wv ? wt : rt, "tag bus");
    tick(1);
    chk({rd_strobe_o, wr_strobe_o}, {rv, wv}, "capture strobes");
    if (rv) chk({rd_tag_o, rd_data_o}, {rt, rd}, "read capture");
    if (wv) chk({wr_tag_o, wr_data_o}, {wt, wd}, "write capture");
  endtask
  task automatic t_read();
    xfer(1, 0, 1, 0, 64'h0123_4567_89ab_cdef, '0, 5'h15, '0);
  endtask
  task automatic t_write();
    xfer(0, 1, 0, 1, '0, 64'hfedc_ba98_7654_3210, '0, 5'h0a);
  endtask
  task automatic t_collide();
    xfer(1, 1, 1, 1, 64'haaaa_5555_aaaa_5555, 64'h5555_aaaa_5555_aaaa, 5'h1f, 5'h01);
  endtask
  task automatic t_spec();
    xfer(1, 0, 0, 1, 64'hffff_0000_ffff_0000, '0, 5'h10, '0);
    xfer(0, 1, 1, 0, '0, 64'h0000_ffff_0000_ffff, '0, 5'h0f);
  endtask
  task automatic t_side();
    {uop_vld_i, uop_i, tag_status_i} = {1'b1, 16'ha5c3, 6'h2d};
    {compat_en_i, out_type_i, term_i, no_error_i} = {1'b1, 2'h2, 2'h1, 1'b0};
    tick(1);
    uop_vld_i = 1'b0;
    chk({uop_vld_o, uop_o}, {1'b1, 16'ha5c3}, "micro-op");
    chk(tag_status_o, 6'h2d, "tag status");
    chk(out_type_o, 2'h2, "output type");
    tick(1);
    chk({term_o, no_error_o}, {2'h1, 1'b0}, "termination, no-error");
    compat_en_i = 1'b0;
    tick(1);
    chk({out_type_o, no_error_o}, {2'h0, 1'b1}, "handshakes disabled");
  endtask
  initial begin
    {arst_n_i, uop_vld_i, rd_req_i, rd_usable_i, wr_req_i, wr_ready_i, compat_en_i} = '0;
    {uop_i, tag_status_i, out_type_i, rd_data_i, wr_data_i, rd_tag_i, wr_tag_i} = '0;
    {term_i, no_error_i} = 3'b111;
    tick(8);
    chk({i_lnk.read_request_out, i_lnk.write_request_in}, 2'b00, "reset req");
    chk(i_lnk.cpu_data_oe, 1'b1, "reset owner");
    arst_n_i = 1'b1;
    t_read();
    t_write();
    t_collide();
    t_spec();
    t_side();
    results();
  end
endmodule
